// ### modbus_rtu_slave.sv
// modbus-rtu request handler: frame check, parameter access, reply builder
`timescale 1ns/1ps
module modbus_rtu_slave (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  comm_station_id_setting,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic        rx_end,
  output logic             reg_req,
  output logic             reg_we,
  output logic [15:0]      reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic        reg_ack,
  input  wire logic [15:0] reg_rdata,
  input  wire logic [1:0]  reg_status,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  output logic             tx_valid,
  input  wire logic        tx_ready
);

  modbus_pkg::state_e state, next_state;
  logic [8:0]  rx_len, next_rx_len, tx_idx, next_tx_idx, rsp_len;
  logic [15:0] rx_crc, next_rx_crc, tx_crc, next_tx_crc, count, op_count;
  logic        ovf, next_ovf, exc, next_exc;
  logic [7:0]  exc_code, next_exc_code, idx, next_idx, fn, rsp_byte;
  logic [7:0]  wofs, word_sel;
  logic        mem_we, rd_we, is_read, fn_known, shape_ok, drop;
  logic        push, in_ready, push_last;
  logic [7:0]  push_data;
  logic [7:0]  rxm [0:255];
  logic [15:0] rdw [0:127];

  ////////////////////////////////////////////////////////////////////////
  // frame decode

  assign fn       = rxm[1];
  assign count    = {rxm[4], rxm[5]};
  assign is_read  = (fn == modbus_pkg::FN_READ_HOLD) ||
                    (fn == modbus_pkg::FN_READ_INPUT);
  assign fn_known = is_read || (fn == modbus_pkg::FN_WRITE_ONE) ||
                    (fn == modbus_pkg::FN_WRITE_MANY);
  // residue of a good frame run through its own crc is zero
  assign drop = (rx_len < modbus_pkg::MIN_FRAME) || ovf ||
                (rx_crc != 16'h0000) ||
                (rxm[0] != comm_station_id_setting);

  always_comb begin
    shape_ok = 1'b0;
    if (is_read) begin
      shape_ok = (rx_len == modbus_pkg::QUERY_LEN) &&
                 (count != 16'h0000) && (count <= modbus_pkg::MAX_READ);
    end else if (fn == modbus_pkg::FN_WRITE_ONE) begin
      shape_ok = (rx_len == modbus_pkg::QUERY_LEN);
    end else if (fn == modbus_pkg::FN_WRITE_MANY) begin
      shape_ok = (count != 16'h0000) && (count <= modbus_pkg::MAX_WRITE) &&
                 (rxm[6] == {count[6:0], 1'b0}) &&
                 (rx_len == modbus_pkg::MANY_HDR_LEN + {1'b0, rxm[6]});
    end
  end

  assign op_count = (fn == modbus_pkg::FN_WRITE_ONE) ? 16'h0001 : count;

  ////////////////////////////////////////////////////////////////////////
  // parameter access, one register per handshake

  assign wofs      = modbus_pkg::DATA_FIRST + {idx[6:0], 1'b0};
  assign reg_req   = (state == modbus_pkg::ST_EXEC);
  assign reg_we    = !is_read;
  assign reg_addr  = {rxm[2], rxm[3]} + {8'h00, idx};
  assign reg_wdata = (fn == modbus_pkg::FN_WRITE_ONE) ?
                     {rxm[4], rxm[5]} : {rxm[wofs], rxm[wofs + 8'h01]};

  ////////////////////////////////////////////////////////////////////////
  // reply bytes

  always_comb begin
    rsp_len = modbus_pkg::RSP_ECHO_LEN;
    if (exc) begin
      rsp_len = modbus_pkg::RSP_SHORT_LEN;
    end else if (is_read) begin
      rsp_len = modbus_pkg::RSP_SHORT_LEN + {count[7:0], 1'b0};
    end
  end

  assign word_sel = tx_idx[7:0] - 8'h03;

  always_comb begin
    rsp_byte = rxm[tx_idx[7:0]];
    if (tx_idx == 9'h001) begin
      rsp_byte = exc ? (fn | modbus_pkg::EXC_FLAG) : fn;
    end else if (tx_idx == 9'h002) begin
      if (exc) begin
        rsp_byte = exc_code;
      end else if (is_read) begin
        rsp_byte = {count[6:0], 1'b0};
      end
    end else if (tx_idx > 9'h002 && is_read) begin
      rsp_byte = word_sel[0] ? rdw[word_sel[7:1]][7:0]
                             : rdw[word_sel[7:1]][15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  assign rx_ready = (state == modbus_pkg::ST_RECV);
  assign push = in_ready && ((state == modbus_pkg::ST_SEND) ||
                (state == modbus_pkg::ST_CRC_LO) ||
                (state == modbus_pkg::ST_CRC_HI));

  always_comb begin
    push_data = rsp_byte;
    push_last = 1'b0;
    if (state == modbus_pkg::ST_CRC_LO) begin
      push_data = tx_crc[7:0];
    end else if (state == modbus_pkg::ST_CRC_HI) begin
      push_data = tx_crc[15:8];
      push_last = 1'b1;
    end
  end

  always_comb begin
    next_state    = state;
    next_rx_len   = rx_len;
    next_rx_crc   = rx_crc;
    next_ovf      = ovf;
    next_idx      = idx;
    next_exc      = exc;
    next_exc_code = exc_code;
    next_tx_idx   = tx_idx;
    next_tx_crc   = tx_crc;
    mem_we        = 1'b0;
    rd_we         = 1'b0;
    case (state)
      modbus_pkg::ST_RECV: begin
        if (rx_valid) begin
          // oversize frames stop storing at FRAME_MAX and are flagged only to be dropped later
          if (rx_len == modbus_pkg::FRAME_MAX) begin
            next_ovf = 1'b1;
          end else begin
            mem_we      = 1'b1;
            next_rx_len = rx_len + 9'h001;
          end
          next_rx_crc = modbus_pkg::crc_step(rx_crc, rx_data);
        end else if (rx_end) begin
          next_state = modbus_pkg::ST_CHECK;
        end
      end
      modbus_pkg::ST_CHECK: begin
        next_idx    = 8'h00;
        next_exc    = 1'b0;
        next_tx_idx = 9'h000;
        next_tx_crc = modbus_pkg::CRC_INIT;
        if (drop) begin
          next_state  = modbus_pkg::ST_RECV;
          next_rx_len = 9'h000;
          next_rx_crc = modbus_pkg::CRC_INIT;
          next_ovf    = 1'b0;
        end else if (!fn_known) begin
          next_exc      = 1'b1;
          next_exc_code = modbus_pkg::EXC_FUNCTION;
          next_state    = modbus_pkg::ST_SEND;
        end else if (!shape_ok) begin
          next_exc      = 1'b1;
          next_exc_code = modbus_pkg::EXC_VALUE;
          next_state    = modbus_pkg::ST_SEND;
        end else begin
          next_state = modbus_pkg::ST_EXEC;
        end
      end
      modbus_pkg::ST_EXEC: begin
        if (reg_ack) begin
          if (reg_status != modbus_pkg::REG_OK) begin
            next_exc   = 1'b1;
            next_state = modbus_pkg::ST_SEND;
            case (reg_status)
              modbus_pkg::REG_BAD_ADDR: next_exc_code = modbus_pkg::EXC_ADDRESS;
              modbus_pkg::REG_BAD_VALUE: next_exc_code = modbus_pkg::EXC_VALUE;
              default: next_exc_code = modbus_pkg::EXC_BUSY;
            endcase
          end else begin
            rd_we    = is_read;
            next_idx = idx + 8'h01;
            if ({8'h00, next_idx} == op_count) begin
              next_state = modbus_pkg::ST_SEND;
            end
          end
        end
      end
      modbus_pkg::ST_SEND: begin
        if (push) begin
          next_tx_crc = modbus_pkg::crc_step(tx_crc, rsp_byte);
          next_tx_idx = tx_idx + 9'h001;
          if (tx_idx == rsp_len - 9'h001) begin
            next_state = modbus_pkg::ST_CRC_LO;
          end
        end
      end
      modbus_pkg::ST_CRC_LO: begin
        if (push) begin
          next_state = modbus_pkg::ST_CRC_HI;
        end
      end
      default: begin
        if (push) begin
          next_state  = modbus_pkg::ST_RECV;
          next_rx_len = 9'h000;
          next_rx_crc = modbus_pkg::CRC_INIT;
          next_ovf    = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= modbus_pkg::ST_RECV;
      rx_len   <= 9'h000;
      rx_crc   <= modbus_pkg::CRC_INIT;
      ovf      <= 1'b0;
      idx      <= 8'h00;
      exc      <= 1'b0;
      exc_code <= 8'h00;
      tx_idx   <= 9'h000;
      tx_crc   <= modbus_pkg::CRC_INIT;
    end else begin
      state    <= next_state;
      rx_len   <= next_rx_len;
      rx_crc   <= next_rx_crc;
      ovf      <= next_ovf;
      idx      <= next_idx;
      exc      <= next_exc;
      exc_code <= next_exc_code;
      tx_idx   <= next_tx_idx;
      tx_crc   <= next_tx_crc;
    end
  end

  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      rxm[rx_len[7:0]] <= rx_data;
    end
    if (rd_we) begin
      rdw[idx[6:0]] <= reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry reply buffer, a stalled receiver halts the sequencer

  logic [7:0] bf_data [0:1];
  logic [1:0] bf_last;
  logic       wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [1:0] bf_cnt, next_bf_cnt;
  logic       pop;

  assign in_ready = (bf_cnt != 2'h2);
  assign tx_valid = (bf_cnt != 2'h0);
  assign pop      = tx_valid && tx_ready;
  assign tx_data  = bf_data[rd_ptr];
  assign tx_last  = bf_last[rd_ptr];

  always_comb begin
    next_wr_ptr = push ? !wr_ptr : wr_ptr;
    next_rd_ptr = pop ? !rd_ptr : rd_ptr;
    next_bf_cnt = bf_cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      bf_cnt  <= 2'h0;
      bf_last <= 2'h0;
      bf_data <= '{8'h00, 8'h00};
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      bf_cnt <= next_bf_cnt;
      if (push) begin
        bf_data[wr_ptr] <= push_data;
        bf_last[wr_ptr] <= push_last;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_STATION_ONLY: assert property (
    state == modbus_pkg::ST_CHECK && rxm[0] != comm_station_id_setting
    |=> state == modbus_pkg::ST_RECV && !tx_valid)
    else $error("frame for another station was answered");
  AST_CRC_DROP: assert property (
    state == modbus_pkg::ST_CHECK && rx_crc != 16'h0000
    |=> state == modbus_pkg::ST_RECV ##1 state == modbus_pkg::ST_RECV)
    else $error("frame with bad crc was not dropped");
  AST_READ_HOLD_LEN: assert property (
    state == modbus_pkg::ST_EXEC && fn == modbus_pkg::FN_READ_HOLD
    |-> rx_len == modbus_pkg::QUERY_LEN && !reg_we)
    else $error("read holding executed on a malformed query");
  AST_READ_INPUT_LEN: assert property (
    state == modbus_pkg::ST_EXEC && fn == modbus_pkg::FN_READ_INPUT
    |-> rx_len == modbus_pkg::QUERY_LEN && count <= modbus_pkg::MAX_READ)
    else $error("read input executed on a malformed query");
  AST_SINGLE_ECHO: assert property (
    push && state == modbus_pkg::ST_SEND && !exc &&
    fn == modbus_pkg::FN_WRITE_ONE |-> push_data == rxm[tx_idx[7:0]])
    else $error("preset single reply does not echo the query");
  AST_MANY_SHAPE: assert property (
    state == modbus_pkg::ST_EXEC && fn == modbus_pkg::FN_WRITE_MANY
    |-> rx_len == modbus_pkg::MANY_HDR_LEN + {1'b0, rxm[6]})
    else $error("preset multiple executed with a wrong byte count");
  AST_MANY_REPLY: assert property (
    state == modbus_pkg::ST_SEND && !exc && fn == modbus_pkg::FN_WRITE_MANY
    |-> rsp_len == modbus_pkg::RSP_ECHO_LEN)
    else $error("preset multiple reply has the wrong length");
  AST_EXC_TOP_BIT: assert property (
    push && state == modbus_pkg::ST_SEND && exc && tx_idx == 9'h001
    |-> push_data == (fn | modbus_pkg::EXC_FLAG))
    else $error("exception reply lacks the function top bit");
  AST_EXC_UNKNOWN_FN: assert property (
    state == modbus_pkg::ST_CHECK && !drop && !fn_known
    |=> exc && exc_code == modbus_pkg::EXC_FUNCTION)
    else $error("unsupported function not flagged with code 01");
  AST_ADDR_STEP: assert property (
    reg_req && reg_ack && reg_status == modbus_pkg::REG_OK &&
    state == next_state |=> reg_addr == $past(reg_addr) + 16'h0001)
    else $error("parameter address did not advance by one");

  COV_READ: cover property (state == modbus_pkg::ST_CRC_HI && push && is_read);
  COV_MANY: cover property (state == modbus_pkg::ST_CRC_HI && push &&
                            fn == modbus_pkg::FN_WRITE_MANY);
  COV_EXC: cover property (state == modbus_pkg::ST_CRC_HI && push && exc);
  COV_DROP: cover property (state == modbus_pkg::ST_CHECK && drop);

endmodule : modbus_rtu_slave

// ### modbus_pkg.sv
// constants, states and check-value helper for the modbus request handler
package modbus_pkg;

  localparam logic [7:0]  FN_READ_HOLD  = 8'h03;
  localparam logic [7:0]  FN_READ_INPUT = 8'h04;
  localparam logic [7:0]  FN_WRITE_ONE  = 8'h06;
  localparam logic [7:0]  FN_WRITE_MANY = 8'h10;
  localparam logic [7:0]  EXC_FLAG      = 8'h80;
  localparam logic [7:0]  EXC_FUNCTION  = 8'h01;
  localparam logic [7:0]  EXC_ADDRESS   = 8'h02;
  localparam logic [7:0]  EXC_VALUE     = 8'h03;
  localparam logic [7:0]  EXC_BUSY      = 8'h06;

  localparam logic [15:0] MAX_READ      = 16'h007d;
  localparam logic [15:0] MAX_WRITE     = 16'h007b;
  localparam logic [8:0]  FRAME_MAX     = 9'h100;
  localparam logic [8:0]  MIN_FRAME     = 9'h004;
  localparam logic [8:0]  QUERY_LEN     = 9'h008;
  localparam logic [8:0]  MANY_HDR_LEN  = 9'h009;
  localparam logic [8:0]  RSP_SHORT_LEN = 9'h003;
  localparam logic [8:0]  RSP_ECHO_LEN  = 9'h006;
  localparam logic [7:0]  DATA_FIRST    = 8'h07;

  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'ha001;

  // answer of the parameter store
  localparam logic [1:0]  REG_OK        = 2'h0;
  localparam logic [1:0]  REG_BAD_ADDR  = 2'h1;
  localparam logic [1:0]  REG_BAD_VALUE = 2'h2;
  localparam logic [1:0]  REG_BUSY      = 2'h3;

  typedef enum logic [2:0] {
    ST_RECV, ST_CHECK, ST_EXEC, ST_SEND, ST_CRC_LO, ST_CRC_HI
  } state_e;

  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                            input logic [7:0]  data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_step

endpackage : modbus_pkg

// ### param_store_model.sv
// parameter store model answering the handler's parameter port
`timescale 1ns/1ps
module param_store_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        reg_req,
  input  wire logic        reg_we,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic             reg_ack,
  output logic [15:0]      reg_rdata,
  output logic [1:0]       reg_status
);
  logic [15:0] mem [16];
  logic [3:0]  wait_cnt;
  logic [1:0]  st;

  ////////////////////////////////////////////////////////////////////////////
  // 0x2xxx unmapped, 0x11ff busy, 0xffff refused as a value
  always_comb begin
    st = modbus_pkg::REG_OK;
    if (reg_addr[15:12] == 4'h2) st = modbus_pkg::REG_BAD_ADDR;
    else if (reg_addr == 16'h11ff) st = modbus_pkg::REG_BUSY;
    else if (reg_we && reg_wdata == 16'hffff) st = modbus_pkg::REG_BAD_VALUE;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_ack    <= 1'b0;
      wait_cnt   <= 4'h0;
      reg_rdata  <= 16'h0000;
      reg_status <= 2'h0;
      for (int i = 0; i < 16; i++) mem[i] <= 16'h1000 + 16'(i);
    end else begin
      reg_ack   <= 1'b0;
      // stale data flips so a late sample cannot match by luck
      reg_rdata <= ~reg_rdata;
      if (reg_req && !reg_ack) begin
        if (wait_cnt < (slow ? 4'h5 : 4'h0)) begin
          wait_cnt <= wait_cnt + 4'h1;
        end else begin
          wait_cnt   <= 4'h0;
          reg_ack    <= 1'b1;
          reg_rdata  <= mem[reg_addr[3:0]];
          reg_status <= st;
          if (reg_we && st == modbus_pkg::REG_OK) begin
            mem[reg_addr[3:0]] <= reg_wdata;
          end
        end
      end
    end
  end
endmodule : param_store_model

// ### tb.sv
// self-checking bench for the modbus request handler
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [95:0] q;
    int          ql;
    logic [63:0] r;
    int          rl;
    logic        slow;
    logic        stall;
  } row_s;

  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        rx_valid = 1'b0;
  logic        rx_end = 1'b0;
  logic        tx_ready = 1'b1;
  logic        slow = 1'b0;
  logic        stall = 1'b0;
  logic        rx_ready, reg_req, reg_we, reg_ack, tx_last, tx_valid;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0]  reg_status;
  logic [7:0]  tx_data;
  logic [1:0]  cyc = 2'h0;
  logic [7:0]  rxq [$];
  logic        lastq [$];
  int          error_cnt = 0;
  int          tests_run = 0;
  row_s        rows [11];

  always #20 core_clk = ~core_clk;

  modbus_rtu_slave modbus_rtu_slave_i (
    .core_clk(core_clk), .rst_n(rst_n), .comm_station_id_setting(8'h01),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_end(rx_end), .reg_req(reg_req), .reg_we(reg_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .reg_status(reg_status), .tx_data(tx_data),
    .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready));

  param_store_model param_store_model_i (
    .core_clk(core_clk), .rst_n(rst_n), .slow(slow), .reg_req(reg_req),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_ack(reg_ack), .reg_rdata(reg_rdata), .reg_status(reg_status));

  ////////////////////////////////////////////////////////////////////////////
  // receiver side: stalls three cycles of four when asked
  always @(posedge core_clk) begin
    cyc <= cyc + 2'h1;
    tx_ready <= !stall || (cyc == 2'h3);
    if (tx_valid && tx_ready) begin
      rxq.push_back(tx_data);
      lastq.push_back(tx_last);
    end
  end

  function automatic logic [15:0] crc_b(logic [15:0] c, logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    return c;
  endfunction : crc_b

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic put(logic [7:0] b);
    @(posedge core_clk);
    rx_data  <= b;
    rx_valid <= 1'b1;
  endtask : put

  // sends query with appended check value, compares the whole reply
  task automatic run(row_s w, logic bad_crc);
    logic [15:0] c, e;
    int          n;
    c = 16'hffff;
    e = 16'hffff;
    for (int i = 0; i < w.ql; i++) begin
      c = crc_b(c, w.q[8*(w.ql-1-i) +: 8]);
      put(w.q[8*(w.ql-1-i) +: 8]);
    end
    if (bad_crc) c = ~c;
    put(c[7:0]);
    put(c[15:8]);
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_end   <= 1'b1;
    @(posedge core_clk);
    rx_end <= 1'b0;
    n = 0;
    while ((w.rl == 0 || rxq.size() < w.rl + 2) && n < 400) begin
      @(posedge core_clk);
      n++;
      if (w.rl == 0 && n == 60) break;
    end
    check("reply_len", 16'(rxq.size()), 16'(w.rl == 0 ? 0 : w.rl + 2));
    for (int i = 0; i < w.rl && i < rxq.size(); i++) begin
      e = crc_b(e, w.r[8*(w.rl-1-i) +: 8]);
      check("reply_byte", {8'h00, rxq[i]}, {8'h00, w.r[8*(w.rl-1-i) +: 8]});
    end
    if (w.rl > 0 && rxq.size() == w.rl + 2) begin
      check("crc", {rxq[w.rl+1], rxq[w.rl]}, e);
    end
    // only the crc high byte may carry the end-of-reply flag
    for (int i = 0; i < lastq.size(); i++) begin
      check("tx_last", {15'h0, lastq[i]}, {15'h0, i == w.rl + 1});
    end
    rxq.delete();
    lastq.delete();
    n = 0;
    while (rx_ready !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
  endtask : run

  task automatic summarize();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0]  = '{96'h010311020002, 6, 64'h01030410021003, 7, 0, 0};
    rows[1]  = '{96'h010411000001, 6, 64'h0104021000, 5, 0, 0};
    rows[2]  = '{96'h010611051234, 6, 64'h010611051234, 6, 1, 0};
    rows[3]  = '{96'h0110110200020400320064, 11, 64'h011011020002, 6, 0, 1};
    rows[4]  = '{96'h010311020002, 6, 64'h01030400320064, 7, 1, 1};
    rows[5]  = '{96'h010711000001, 6, 64'h018701, 3, 0, 0};
    rows[6]  = '{96'h010320000001, 6, 64'h018302, 3, 0, 0};
    rows[7]  = '{96'h01061105ffff, 6, 64'h018603, 3, 0, 0};
    rows[8]  = '{96'h010611ff0001, 6, 64'h018606, 3, 1, 0};
    rows[9]  = '{96'h010311000000, 6, 64'h018303, 3, 0, 0};
    rows[10] = '{96'h020311000001, 6, 64'h0, 0, 0, 0};
    repeat (10) @(posedge core_clk);
    check("rst_rx_ready", {15'h0, rx_ready}, 16'h0001);
    check("rst_tx_valid", {15'h0, tx_valid}, 16'h0000);
    check("rst_reg_req", {15'h0, reg_req}, 16'h0000);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      slow  <= rows[i].slow;
      stall <= rows[i].stall;
      run(rows[i], 1'b0);
    end
    // refused value must leave the stored word alone; word 3 keeps the preset multiple data
    check("mem5", param_store_model_i.mem[5], 16'h1234);
    check("mem3", param_store_model_i.mem[3], 16'h0064);
    // corrupted check value: no reply and no write
    run('{96'h010611050abc, 6, 64'h0, 0, 0, 0}, 1'b1);
    check("mem5_crc", param_store_model_i.mem[5], 16'h1234);
    // back-to-back frames after a mid-run reset
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    check("rst2_tx_valid", {15'h0, tx_valid}, 16'h0000);
    rst_n <= 1'b1;
    run('{96'h010311000001, 6, 64'h0103021000, 5, 0, 0}, 1'b0);
    run('{96'h000311000001, 6, 64'h0, 0, 0, 0}, 1'b0);
    summarize();
  end
endmodule : tb
